// ==== rtl/aotf_pkg.sv ====
// Package with register map, field layout and reset values for the offset trim slice
package aotf_pkg;
    // Register byte addresses: the plain port carries the 12-bit device address
    localparam logic [11:0] TRIM_A_LO_ADDR = 12'h092;
    localparam logic [11:0] TRIM_A_HI_ADDR = 12'h093;
    localparam logic [11:0] TRIM_B_LO_ADDR = 12'h094;
    localparam logic [11:0] TRIM_B_HI_ADDR = 12'h095;
    localparam logic [11:0] FILT0_ADDR = 12'h097;
    localparam logic [11:0] FILT1_ADDR = 12'h098;
    // Field layout
    localparam int TRIM_W = 12;
    localparam int TRIM_HI_W = 4;
    localparam int KEEP_DC_BIT = 0;
    localparam int BW_LSB = 4;
    localparam int SOAK_LSB = 0;
    // Reset values
    localparam logic [7:0] FILT0_RST = 8'h00;
    localparam logic [7:0] FILT1_RST = 8'h33;
    localparam logic [11:0] TRIM_FACTORY_DEFAULT = 12'h800;
    // Bandwidth codes and IIR shift amounts
    localparam logic [3:0] BW_CODE_MIN = 4'h1;
    localparam logic [3:0] BW_CODE_MAX = 4'h5;
    localparam logic [4:0] BW_SHIFT_BASE = 5'h09;
    localparam logic [4:0] BW_SHIFT_DEFAULT = 5'h0C;
    // Trim access states
    typedef enum logic [1:0] {
        AOTF_IDLE = 2'b00,
        AOTF_LOAD = 2'b01,
        AOTF_READY = 2'b11
    } aotf_state_t;
endpackage : aotf_pkg

// ==== rtl/aotf_trim_reg.sv ====
// One 12-bit trim register split into a low byte and a 4-bit high half, with factory load
`timescale 1ns/10ps
module aotf_trim_reg
    import aotf_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Factory load
    input wire logic load_i,
    input wire logic [11:0] factory_i,
    // Byte writes
    input wire logic wr_lo_i,
    input wire logic wr_hi_i,
    input wire logic [7:0] wdata_i,
    // Held value
    output logic [11:0] trim_o
);
    logic [11:0] trim_r;
    logic [11:0] trim_nxt;

    // Factory load takes priority; writes touch only their own byte
    always_comb begin
        trim_nxt = trim_r;
        if (load_i) begin
            trim_nxt = factory_i;
        end else begin
            if (wr_lo_i) begin
                trim_nxt[7:0] = wdata_i;
            end
            if (wr_hi_i) begin
                trim_nxt[11:8] = wdata_i[TRIM_HI_W-1:0]; // Reserved upper nibble dropped
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            trim_r <= TRIM_FACTORY_DEFAULT;
        end else begin
            trim_r <= trim_nxt;
        end
    end

    assign trim_o = trim_r;
endmodule : aotf_trim_reg

// ==== rtl/aotf_dc_filter.sv ====
// Offset filter: first-order IIR DC tracker with whole-signal or bank-mismatch removal
`timescale 1ns/10ps
module aotf_dc_filter
    import aotf_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Control
    input wire logic enable_i,
    input wire logic keep_dc_i,
    input wire logic [4:0] shift_i,
    // Sample stream
    input wire logic sample_vld_i,
    input wire logic [11:0] sample_i,
    input wire logic [11:0] mean_i,
    output logic [11:0] data_o
);
    // Accumulator keeps 16 fraction bits so small coefficients still move it
    logic [27:0] acc_r;
    logic [27:0] acc_nxt;
    logic [11:0] data_r;
    logic [11:0] data_nxt;
    logic [11:0] est;
    logic [12:0] diff;

    assign est = acc_r[27:16];

    always_comb begin
        acc_nxt = acc_r;
        data_nxt = data_r;
        diff = 13'h0000;
        if (sample_vld_i) begin
            acc_nxt = acc_r + (({16'h0000, sample_i} << 16) >> shift_i)
                      - (acc_r >> shift_i);
            if (!enable_i) begin
                data_nxt = sample_i;
            end else if (keep_dc_i) begin
                // Only the bank's deviation from the common mean is removed
                diff = {1'b0, sample_i} - {1'b0, est} + {1'b0, mean_i};
                data_nxt = diff[12] ? 12'h000 : diff[11:0];
            end else begin
                // All DC removed; result centred at mid-scale, unsigned
                diff = {1'b0, sample_i} - {1'b0, est} + 13'h0800;
                data_nxt = diff[12] ? 12'h000 : diff[11:0];
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc_r <= 28'h0000000;
            data_r <= 12'h000;
        end else begin
            acc_r <= acc_nxt;
            data_r <= data_nxt;
        end
    end

    assign data_o = data_r;
endmodule : aotf_dc_filter

// ==== rtl/aotf_regs.sv ====
// Offset trim and offset filter control register slice for the third converter core
`timescale 1ns/10ps
module aotf_regs
    import aotf_pkg::*;
(
    // Clock and reset
    input wire logic MCLK_I,
    input wire logic RESETN_I,
    // Register port
    input wire logic [11:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [7:0] RDATA_O,
    // Factory trim values and calibration status
    input wire logic [11:0] FACTORY_TRIM_A_I,
    input wire logic [11:0] FACTORY_TRIM_B_I,
    input wire logic FG_CAL_BUSY_I,
    input wire logic FOREGROUND_CAL_COMPLETE_I,
    input wire logic BACKGROUND_CAL_ENABLE_I,
    input wire logic BACKGROUND_OFFSET_CAL_ENABLE_I,
    input wire logic OFFSET_CAL_ENABLE_I,
    input wire logic BACKGROUND_CAL_HALTED_I,
    input wire logic OFFSET_FILTER_ENABLE_I,
    // Third core sample path
    input wire logic SAMPLE_VLD_I,
    input wire logic SAMPLE_SEL_B_I,
    input wire logic [11:0] SAMPLE_I,
    input wire logic [11:0] BANK_MEAN_I,
    output logic [11:0] CORR_DATA_O,
    output logic [11:0] FILT_DATA_O,
    // Filter settings and access status
    output logic [4:0] IIR_SHIFT_O,
    output logic [3:0] SETTLE_CODE_O,
    output logic BW_RESERVED_O,
    output logic ACCESS_VIOL_O
);
    aotf_state_t state_r;
    aotf_state_t state_nxt;
    logic [7:0] filt0_r;
    logic [7:0] filt0_nxt;
    logic [7:0] filt1_r;
    logic [7:0] filt1_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic [11:0] corr_r;
    logic [11:0] corr_nxt;
    logic corr_vld_r;
    logic corr_vld_nxt;
    logic viol_r;
    logic viol_nxt;
    logic [11:0] trim_a;
    logic [11:0] trim_b;
    logic load;
    logic wr_trim_ok;
    logic rd_trim_ok;
    logic is_trim_addr;
    logic [12:0] corr_sum;
    logic [4:0] shift;

    // Coefficient shift from the bandwidth code; reserved codes keep the default
    function automatic logic [4:0] bw_to_shift(input logic [3:0] code);
        if (code >= BW_CODE_MIN && code <= BW_CODE_MAX) begin
            bw_to_shift = BW_SHIFT_BASE + {1'b0, code};
        end else begin
            bw_to_shift = BW_SHIFT_DEFAULT;
        end
    endfunction : bw_to_shift

    // True for the four trim byte addresses
    function automatic logic trim_addr(input logic [11:0] a);
        trim_addr = (a == TRIM_A_LO_ADDR) || (a == TRIM_A_HI_ADDR) ||
                    (a == TRIM_B_LO_ADDR) || (a == TRIM_B_HI_ADDR);
    endfunction : trim_addr

    // Factory values are loaded once after reset release, not under the async reset
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            AOTF_IDLE: state_nxt = AOTF_LOAD;
            AOTF_LOAD: state_nxt = AOTF_READY;
            AOTF_READY: state_nxt = AOTF_READY;
            default: state_nxt = AOTF_IDLE;
        endcase
    end
    assign load = (state_r == AOTF_LOAD);

    // Access windows; the host is expected to respect them, we only flag a breach
    assign is_trim_addr = trim_addr(ADDR_I);
    assign wr_trim_ok = !FG_CAL_BUSY_I &&
                        !(BACKGROUND_CAL_ENABLE_I && BACKGROUND_OFFSET_CAL_ENABLE_I);
    always_comb begin
        rd_trim_ok = 1'b1;
        if (OFFSET_CAL_ENABLE_I && !BACKGROUND_OFFSET_CAL_ENABLE_I) begin
            rd_trim_ok = FOREGROUND_CAL_COMPLETE_I;
        end
        if (BACKGROUND_CAL_ENABLE_I && BACKGROUND_OFFSET_CAL_ENABLE_I) begin
            rd_trim_ok = BACKGROUND_CAL_HALTED_I;
        end
    end

    // Trim registers; a write outside its window is still taken, as the core would
    aotf_trim_reg u_trim_a (
        .clk_i(MCLK_I),
        .rst_n_i(RESETN_I),
        .load_i(load),
        .factory_i(FACTORY_TRIM_A_I),
        .wr_lo_i(WR_I && ADDR_I == TRIM_A_LO_ADDR),
        .wr_hi_i(WR_I && ADDR_I == TRIM_A_HI_ADDR),
        .wdata_i(WDATA_I),
        .trim_o(trim_a)
    );
    aotf_trim_reg u_trim_b (
        .clk_i(MCLK_I),
        .rst_n_i(RESETN_I),
        .load_i(load),
        .factory_i(FACTORY_TRIM_B_I),
        .wr_lo_i(WR_I && ADDR_I == TRIM_B_LO_ADDR),
        .wr_hi_i(WR_I && ADDR_I == TRIM_B_HI_ADDR),
        .wdata_i(WDATA_I),
        .trim_o(trim_b)
    );

    // Control registers, read data and sticky access flag
    always_comb begin
        filt0_nxt = filt0_r;
        filt1_nxt = filt1_r;
        rdata_nxt = 8'h00;
        viol_nxt = viol_r;
        if (WR_I) begin
            if (ADDR_I == FILT0_ADDR) begin
                filt0_nxt = {7'h00, WDATA_I[KEEP_DC_BIT]};
            end
            if (ADDR_I == FILT1_ADDR) begin
                filt1_nxt = WDATA_I;
            end
            if (is_trim_addr && !wr_trim_ok) begin
                viol_nxt = 1'b1;
            end
        end
        if (RD_I) begin
            case (ADDR_I)
                TRIM_A_LO_ADDR: rdata_nxt = trim_a[7:0];
                TRIM_A_HI_ADDR: rdata_nxt = {4'h0, trim_a[11:8]};
                TRIM_B_LO_ADDR: rdata_nxt = trim_b[7:0];
                TRIM_B_HI_ADDR: rdata_nxt = {4'h0, trim_b[11:8]};
                FILT0_ADDR: rdata_nxt = filt0_r;
                FILT1_ADDR: rdata_nxt = filt1_r;
                default: rdata_nxt = 8'h00; // Unmapped reads return zero
            endcase
            if (is_trim_addr && !rd_trim_ok) begin
                viol_nxt = 1'b1;
            end
        end
    end

    // Trim correction; unsigned add saturating at full scale
    always_comb begin
        corr_nxt = corr_r;
        corr_vld_nxt = SAMPLE_VLD_I;
        corr_sum = 13'h0000;
        if (SAMPLE_VLD_I) begin
            if (SAMPLE_SEL_B_I) begin
                corr_sum = {1'b0, SAMPLE_I} + {1'b0, trim_b};
            end else begin
                corr_sum = {1'b0, SAMPLE_I} + {1'b0, trim_a};
            end
            corr_nxt = corr_sum[12] ? 12'hFFF : corr_sum[11:0];
        end
    end

    always_ff @(posedge MCLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            state_r <= AOTF_IDLE;
            filt0_r <= FILT0_RST;
            filt1_r <= FILT1_RST;
            rdata_r <= 8'h00;
            corr_r <= 12'h000;
            corr_vld_r <= 1'b0;
            viol_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            filt0_r <= filt0_nxt;
            filt1_r <= filt1_nxt;
            rdata_r <= rdata_nxt;
            corr_r <= corr_nxt;
            corr_vld_r <= corr_vld_nxt;
            viol_r <= viol_nxt;
        end
    end

    assign shift = bw_to_shift(filt1_r[BW_LSB+3:BW_LSB]);

    // Filter follows the trimmed stream, one cycle behind it
    aotf_dc_filter u_filter (
        .clk_i(MCLK_I),
        .rst_n_i(RESETN_I),
        .enable_i(OFFSET_FILTER_ENABLE_I),
        .keep_dc_i(filt0_r[KEEP_DC_BIT]),
        .shift_i(shift),
        .sample_vld_i(corr_vld_r),
        .sample_i(corr_r),
        .mean_i(BANK_MEAN_I),
        .data_o(FILT_DATA_O)
    );

    assign RDATA_O = rdata_r;
    assign CORR_DATA_O = corr_r;
    assign IIR_SHIFT_O = shift;
    assign SETTLE_CODE_O = filt1_r[SOAK_LSB+3:SOAK_LSB]; // value used as written
    assign BW_RESERVED_O = (filt1_r[BW_LSB+3:BW_LSB] < BW_CODE_MIN) ||
                           (filt1_r[BW_LSB+3:BW_LSB] > BW_CODE_MAX);
    assign ACCESS_VIOL_O = viol_r;
endmodule : aotf_regs

// ==== test/aotf_regs_assertions.sv ====
// Checker with concurrent properties on the trim and filter register slice ports
`timescale 1ns/10ps
module aotf_regs_chk
    import aotf_pkg::*;
(
    // Clock, reset and bus
    input wire logic MCLK_I,
    input wire logic RESETN_I,
    input wire logic [11:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic [7:0] RDATA_O,
    // Calibration status
    input wire logic FG_CAL_BUSY_I,
    input wire logic FOREGROUND_CAL_COMPLETE_I,
    input wire logic BACKGROUND_CAL_ENABLE_I,
    input wire logic BACKGROUND_OFFSET_CAL_ENABLE_I,
    input wire logic OFFSET_CAL_ENABLE_I,
    input wire logic BACKGROUND_CAL_HALTED_I,
    // Watched outputs
    input wire logic [4:0] IIR_SHIFT_O,
    input wire logic BW_RESERVED_O,
    input wire logic ACCESS_VIOL_O
);
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!RESETN_I);
    // Any byte of either trim register
    logic trim_hit;
    logic bg_both;
    assign trim_hit = ADDR_I inside {TRIM_A_LO_ADDR, TRIM_A_HI_ADDR,
                                     TRIM_B_LO_ADDR, TRIM_B_HI_ADDR};
    assign bg_both = BACKGROUND_CAL_ENABLE_I && BACKGROUND_OFFSET_CAL_ENABLE_I;
    // Reads whose data must show cleared reserved bits next cycle
    sequence s_hi_rd;
        RD_I && (ADDR_I == TRIM_A_HI_ADDR || ADDR_I == TRIM_B_HI_ADDR);
    endsequence
    sequence s_f0_rd;
        RD_I && ADDR_I == FILT0_ADDR;
    endsequence
    a_hi_nibble_zero: assert property (s_hi_rd |=> RDATA_O[7:4] == 4'h0)
        else $error("trim upper nibble not zero");
    a_filt0_upper_zero: assert property (s_f0_rd |=> RDATA_O[7:1] == 7'h00)
        else $error("filter control zero upper bits not zero");
    a_rdata_only_after: assert property (RDATA_O != 8'h00 |-> $past(RD_I))
        else $error("read data outside the read answer cycle");
    a_wr_fg_busy: assert property (WR_I && trim_hit && FG_CAL_BUSY_I |=> ACCESS_VIOL_O)
        else $error("trim write during foreground cal not flagged");
    a_wr_bg_both: assert property (WR_I && trim_hit && bg_both |=> ACCESS_VIOL_O)
        else $error("trim write with background enables not flagged");
    a_rd_before_done: assert property (RD_I && trim_hit && OFFSET_CAL_ENABLE_I
        && !BACKGROUND_OFFSET_CAL_ENABLE_I && !FOREGROUND_CAL_COMPLETE_I |=> ACCESS_VIOL_O)
        else $error("early trim read not flagged");
    a_rd_not_halted: assert property (RD_I && trim_hit && bg_both
        && !BACKGROUND_CAL_HALTED_I |=> ACCESS_VIOL_O)
        else $error("trim read while running not flagged");
    a_viol_sticky: assert property (ACCESS_VIOL_O |=> ACCESS_VIOL_O)
        else $error("access flag cleared without reset");
    a_bw_shift_map: assert property (WR_I && ADDR_I == FILT1_ADDR |=> IIR_SHIFT_O ==
        (($past(WDATA_I[7:4]) inside {[1:5]}) ? 5'h09 + $past(WDATA_I[7:4]) : 5'h0C))
        else $error("bandwidth code maps to wrong shift");
    a_bw_reserved: assert property (BW_RESERVED_O |-> IIR_SHIFT_O == 5'h0C)
        else $error("reserved bandwidth code not on default shift");
endmodule : aotf_regs_chk
// Implicit by-name hookup keeps the bind short
bind aotf_regs aotf_regs_chk u_chk (.*);

// ==== test/tb_aotf_regs.sv ====
// Self-checking bench for the trim and filter register slice
`timescale 1ns/10ps
module tb_aotf_regs;
    import aotf_pkg::*;
    logic MCLK_I = 1'b0, RESETN_I = 1'b0, WR_I = 1'b0, RD_I = 1'b0;
    logic [11:0] ADDR_I = 12'h000, SAMPLE_I = 12'h000, BANK_MEAN_I = 12'h000;
    logic [11:0] FACTORY_TRIM_A_I = 12'h123, FACTORY_TRIM_B_I = 12'h456;
    logic [7:0] WDATA_I = 8'h00;
    logic FG_CAL_BUSY_I = 1'b0, FOREGROUND_CAL_COMPLETE_I = 1'b0, BACKGROUND_CAL_ENABLE_I = 1'b0;
    logic BACKGROUND_OFFSET_CAL_ENABLE_I = 1'b0, OFFSET_CAL_ENABLE_I = 1'b0;
    logic BACKGROUND_CAL_HALTED_I = 1'b0, OFFSET_FILTER_ENABLE_I = 1'b0;
    logic SAMPLE_VLD_I = 1'b0, SAMPLE_SEL_B_I = 1'b0;
    logic [7:0] RDATA_O;
    logic [11:0] CORR_DATA_O, FILT_DATA_O;
    logic [4:0] IIR_SHIFT_O;
    logic [3:0] SETTLE_CODE_O;
    logic BW_RESERVED_O, ACCESS_VIOL_O;
    int errors = 0, compares = 0, cycles = 0;
    aotf_regs uut (.*);
    // 100 ns clock
    always #50 MCLK_I = ~MCLK_I;
    // Hang guard, well above the filter soak
    always @(posedge MCLK_I) begin
        cycles++;
        if (cycles == 40000) begin
            errors++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input string w, input logic [11:0] e, input logic [11:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", w, e, g);
        end
    endtask : chk
    // Reset, then wait out the factory load before the first request
    task automatic rst();
        // Align to an edge so reset is driven like every other input
        @(posedge MCLK_I);
        RESETN_I <= 1'b0;
        repeat (10) @(posedge MCLK_I);
        RESETN_I <= 1'b1;
        repeat (3) @(posedge MCLK_I);
    endtask : rst
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge MCLK_I);
        WR_I <= 1'b1;
        ADDR_I <= a;
        WDATA_I <= d;
        @(posedge MCLK_I);
        WR_I <= 1'b0;
        #1;
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task automatic rc(input logic [11:0] a, input logic [7:0] e, input string w);
        @(posedge MCLK_I);
        RD_I <= 1'b1;
        ADDR_I <= a;
        @(posedge MCLK_I);
        RD_I <= 1'b0;
        #1 chk(w, {4'h0, e}, {4'h0, RDATA_O});
    endtask : rc
    task automatic smp(input logic b, input logic [11:0] s, input logic [11:0] e);
        @(posedge MCLK_I);
        SAMPLE_VLD_I <= 1'b1;
        SAMPLE_SEL_B_I <= b;
        SAMPLE_I <= s;
        @(posedge MCLK_I);
        SAMPLE_VLD_I <= 1'b0;
        #1 chk("corrected sample", e, CORR_DATA_O);
    endtask : smp
    task automatic t_reset();
        rc(TRIM_A_LO_ADDR, 8'h23, "trim a lo");
        rc(TRIM_A_HI_ADDR, 8'h01, "trim a hi");
        rc(TRIM_B_LO_ADDR, 8'h56, "trim b lo");
        rc(TRIM_B_HI_ADDR, 8'h04, "trim b hi");
        rc(FILT0_ADDR, 8'h00, "filt0 reset");
        rc(FILT1_ADDR, 8'h33, "filt1 reset");
        rc(12'h096, 8'h00, "unmapped");
        chk("reset shift", 12'h00C, {7'h00, IIR_SHIFT_O});
        chk("no flag", 12'h000, {11'h000, ACCESS_VIOL_O});
        $display("t_reset done");
    endtask : t_reset
    task automatic t_regs();
        logic [3:0] c;
        wr(FILT0_ADDR, 8'hFF);
        rc(FILT0_ADDR, 8'h01, "filt0 bits");
        for (int i = 0; i < 16; i++) begin
            c = i[3:0];
            wr(FILT1_ADDR, {c, c});
            chk("shift", (c >= 4'h1 && c <= 4'h5) ? 12'h009 + c : 12'h00C, IIR_SHIFT_O);
            chk("reserved", {11'h000, c == 4'h0 || c > 4'h5}, BW_RESERVED_O);
            chk("settle", {8'h00, c}, {8'h00, SETTLE_CODE_O});
        end
        wr(TRIM_A_HI_ADDR, 8'hFF);
        rc(TRIM_A_HI_ADDR, 8'h0F, "trim hi mask");
        $display("t_regs done");
    endtask : t_regs
    task automatic t_corr();
        wr(TRIM_A_LO_ADDR, 8'h00);
        wr(TRIM_A_HI_ADDR, 8'h09);
        wr(TRIM_B_LO_ADDR, 8'hA5);
        wr(TRIM_B_HI_ADDR, 8'h00);
        smp(1'b0, 12'h100, 12'hA00);
        smp(1'b1, 12'h800, 12'h8A5);
        smp(1'b0, 12'h800, 12'hFFF);
        // With the filter off its output follows the trimmed stream one cycle later
        @(posedge MCLK_I);
        #1 chk("filter bypass", 12'hFFF, FILT_DATA_O);
        $display("t_corr done");
    endtask : t_corr
    // Long soak lets the tracker settle on a constant input
    task automatic t_filt();
        wr(FILT1_ADDR, 8'h11);
        wr(FILT0_ADDR, 8'h00);
        @(posedge MCLK_I);
        OFFSET_FILTER_ENABLE_I <= 1'b1;
        SAMPLE_VLD_I <= 1'b1;
        SAMPLE_SEL_B_I <= 1'b0;
        SAMPLE_I <= 12'h100;
        BANK_MEAN_I <= 12'h300;
        repeat (12000) @(posedge MCLK_I);
        #1 chk("dc removed", 12'h001, FILT_DATA_O >= 12'h7FC && FILT_DATA_O <= 12'h804);
        wr(FILT0_ADDR, 8'h01);
        repeat (4) @(posedge MCLK_I);
        #1 chk("dc kept", 12'h001, FILT_DATA_O >= 12'h2FC && FILT_DATA_O <= 12'h304);
        @(posedge MCLK_I);
        SAMPLE_VLD_I <= 1'b0;
        OFFSET_FILTER_ENABLE_I <= 1'b0;
        $display("t_filt done");
    endtask : t_filt
    // Each row: busy, done, bg, bgos, os, halted, write, flag expected
    task automatic t_viol();
        logic [7:0] tbl [7] = '{8'h83, 8'h33, 8'h22, 8'h09, 8'h48, 8'h31, 8'h34};
        for (int i = 0; i < 7; i++) begin
            rst();
            {FG_CAL_BUSY_I, FOREGROUND_CAL_COMPLETE_I, BACKGROUND_CAL_ENABLE_I} <= tbl[i][7:5];
            {BACKGROUND_OFFSET_CAL_ENABLE_I, OFFSET_CAL_ENABLE_I} <= tbl[i][4:3];
            BACKGROUND_CAL_HALTED_I <= tbl[i][2];
            if (tbl[i][1]) begin
                wr(TRIM_B_LO_ADDR, 8'h5A);
            end else begin
                rc(TRIM_B_LO_ADDR, 8'h56, "window read");
            end
            repeat (2) @(posedge MCLK_I);
            #1 chk("access flag", {11'h000, tbl[i][0]}, ACCESS_VIOL_O);
            @(posedge MCLK_I);
            {FG_CAL_BUSY_I, FOREGROUND_CAL_COMPLETE_I, BACKGROUND_CAL_ENABLE_I} <= 3'h0;
            {BACKGROUND_OFFSET_CAL_ENABLE_I, OFFSET_CAL_ENABLE_I} <= 2'h0;
            BACKGROUND_CAL_HALTED_I <= 1'b0;
        end
        rc(TRIM_B_LO_ADDR, 8'h56, "reload after reset");
        $display("t_viol done");
    endtask : t_viol
    initial begin
        rst();
        t_reset();
        t_regs();
        t_corr();
        t_filt();
        t_viol();
        end_sim();
    end
endmodule : tb_aotf_regs
